// file: dv/led_photo_cfg_monitor.sv
// Bus and field checker for the LED and photo configuration registers
`timescale 1ns/10ps
module led_photo_cfg_monitor (
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    input logic hreadyout,
    input logic hresp,
    input logic [31:0] hrdata,
    input led_photo_cfg_pkg::analog_cfg_s analog_cfg,
    input logic level_reserved_q
);
    logic tk, rd, um;
    logic [3:0] wr;
    // Taken transfers, decoded per register
    assign tk = hsel & hready & htrans[1];
    assign rd = tk & ~hwrite;
    assign um = !(haddr inside {32'h3C, 32'h40, 32'h44, 32'h48});
    assign wr[0] = tk & hwrite & (hsize == 3'h2) & (haddr == 32'h3C);
    assign wr[1] = tk & hwrite & (hsize == 3'h2) & (haddr == 32'h40);
    assign wr[2] = tk & hwrite & (hsize == 3'h2) & (haddr == 32'h44);
    assign wr[3] = tk & hwrite & (hsize == 3'h2) & (haddr == 32'h48);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_level_store: assert property (wr[0] |-> ##3 analog_cfg[25:23] == $past(hwdata[3:1], 2))
        else $error("regulator level not stored");
    a_photo_store: assert property (wr[1] |-> ##3 analog_cfg[22:16] == $past(hwdata[6:0], 2))
        else $error("photo control not stored");
    a_first_current: assert property (wr[2] |-> ##3 analog_cfg[15:8] == $past(hwdata[7:0], 2))
        else $error("first current not stored");
    a_second_current: assert property (wr[3] |-> ##3 analog_cfg[7:0] == $past(hwdata[7:0], 2))
        else $error("second current not stored");
    a_level_reserved: assert property (rd && haddr == 32'h3C |=> hrdata[7:4] == 4'h0 && !hrdata[0])
        else $error("regulator reserved bits set");
    a_photo_reserved: assert property (rd && haddr == 32'h40 |=> !hrdata[7])
        else $error("photo reserved bit set");
    a_unmapped_zero: assert property (rd && um |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_flag_matches: assert property (level_reserved_q == (analog_cfg[25:23] > 3'h5))
        else $error("reserved level flag wrong");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("wait state or error response");
    c_level_write: cover property (wr[0]);
    c_photo_read: cover property (rd && haddr == 32'h40);
    c_reserved_level: cover property (level_reserved_q);
endmodule : led_photo_cfg_monitor

bind led_photo_config_registers led_photo_cfg_monitor led_photo_cfg_monitor_inst (.hclk,
    .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .analog_cfg, .level_reserved_q);

// file: dv/tb.sv
// Self-checking bench of the LED and photo configuration registers
`timescale 1ns/10ps
module tb;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, level_reserved_q;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    led_photo_cfg_pkg::analog_cfg_s analog_cfg;
    logic [7:0] m[4];
    logic [31:0] at[7];
    int miscompares, comparisons;
    assign hready = hreadyout;
    led_photo_config_registers led_photo_config_registers_inst (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .analog_cfg,
        .level_reserved_q);
    // Clock of 50 ns
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic test_done();
        if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Writable bits of each word address
    function automatic logic [7:0] mk(input logic [31:0] a);
        case (a)
            32'h3C: return 8'h0E;
            32'h40: return 8'h7F;
            32'h44, 32'h48: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction : mk
    // One single word transfer; read data lands in r
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask : bus
    // Write, read back, compare readback and analog settings
    task automatic wc(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        if (mk(a) != 8'h00) m[a[6:2] - 5'hF] = d[7:0] & mk(a);
        bus(1'b0, a, 32'h0);
        chk(r, {24'h0, d[7:0] & mk(a)});
        chk({6'h0, analog_cfg}, {6'h0, m[0][3:1], m[1][6:0], m[2], m[3]});
        chk({31'h0, level_reserved_q}, {31'h0, m[0][3:1] > 3'h5});
    endtask : wc
    // Reset values of all registers
    task automatic rz();
        for (int k = 0; k < 4; k++) begin
            bus(1'b0, at[k], 32'h0);
            chk(r, 32'h0);
        end
        chk({6'h0, analog_cfg}, 32'h0);
    endtask : rz
    // Main sequence
    initial begin
        hresetn <= 1'b0;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        haddr <= 32'h0;
        hwdata <= 32'h0;
        r = $urandom(32'h8C6DB49E);
        at = '{32'h3C, 32'h40, 32'h44, 32'h48, 32'h4C, 32'h38, 32'h0};
        m = '{default: 8'h00};
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rz();
        for (int k = 0; k < 8; k++) wc(32'h3C, {28'hFFFFFFF, k[2:0], 1'b1});
        for (int k = 0; k < 7; k++) wc(at[k], 32'hFFFFFFFF);
        repeat (60) wc(at[$urandom_range(6)], $urandom);
        hresetn <= 1'b0;
        m = '{default: 8'h00};
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rz();
        test_done();
    end
    // Watchdog against a hung transfer
    initial begin
        #100000;
        miscompares++;
        test_done();
    end
endmodule : tb

// file: hw/cfg_byte_reg.sv
// One configuration byte with a fixed writable mask
`timescale 1ns/10ps
module cfg_byte_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK = 8'hFF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] value_q
);

    // Only masked bits are stored, so reserved bits stay zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            value_q <= RESET_VALUE & WRITE_MASK;
        end else if (wr_en) begin
            value_q <= wr_data & WRITE_MASK;
        end
    end

endmodule : cfg_byte_reg

// file: hw/led_photo_cfg_pkg.sv
// Constants, field layout and types of the LED and photo configuration registers
package led_photo_cfg_pkg;

    // Register geometry
    localparam int REG_W = 8;
    localparam int NUM_REGS = 4;
    localparam int BUS_W = 32;
    localparam int WORD_SHIFT = 2;

    // Printed offsets are register indices; byte address is four times that
    localparam logic [29:0] IDX_LED_REGULATOR = 30'h0000000F;
    localparam logic [29:0] IDX_PHOTO_CONTROL = 30'h00000010;
    localparam logic [29:0] IDX_FIRST_CURRENT = 30'h00000011;
    localparam logic [29:0] IDX_SECOND_CURRENT = 30'h00000012;
    localparam logic [31:0] ADDR_LED_REGULATOR = {IDX_LED_REGULATOR, 2'h0};
    localparam logic [31:0] ADDR_PHOTO_CONTROL = {IDX_PHOTO_CONTROL, 2'h0};
    localparam logic [31:0] ADDR_FIRST_CURRENT = {IDX_FIRST_CURRENT, 2'h0};
    localparam logic [31:0] ADDR_SECOND_CURRENT = {IDX_SECOND_CURRENT, 2'h0};

    // Slot numbers inside the register array
    localparam int SLOT_LED_REGULATOR = 0;
    localparam int SLOT_PHOTO_CONTROL = 1;
    localparam int SLOT_FIRST_CURRENT = 2;
    localparam int SLOT_SECOND_CURRENT = 3;

    // Field positions
    localparam int LEVEL_LSB = 1;
    localparam int LEVEL_W = 3;
    localparam int SECOND_SLOPE_LSB = 5;
    localparam int FIRST_SLOPE_LSB = 3;
    localparam int SLOPE_W = 2;
    localparam int REF_SEL_BIT = 2;
    localparam int GAIN_LSB = 0;
    localparam int GAIN_W = 2;

    // Writable bit masks; all other bits are reserved and read zero
    localparam logic [REG_W-1:0] MASK_LED_REGULATOR = 8'h0E;
    localparam logic [REG_W-1:0] MASK_PHOTO_CONTROL = 8'h7F;
    localparam logic [REG_W-1:0] MASK_FULL = 8'hFF;

    // Reset values
    localparam logic [REG_W-1:0] RST_LED_REGULATOR = 8'h00;
    localparam logic [REG_W-1:0] RST_PHOTO_CONTROL = 8'h00;
    localparam logic [REG_W-1:0] RST_FIRST_CURRENT = 8'h00;
    localparam logic [REG_W-1:0] RST_SECOND_CURRENT = 8'h00;

    // Highest regulator level code that is not reserved (10 V)
    localparam logic [LEVEL_W-1:0] LEVEL_MAX_VALID = 3'h5;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // Regulator output level codes
    typedef enum logic [LEVEL_W-1:0] {
        LEVEL_7V5 = 3'h0,
        LEVEL_8V0 = 3'h1,
        LEVEL_8V5 = 3'h2,
        LEVEL_9V0 = 3'h3,
        LEVEL_9V5 = 3'h4,
        LEVEL_10V = 3'h5
    } led_regulator_level_e;

    // Settings handed to the analog circuitry
    typedef struct packed {
        logic [LEVEL_W-1:0] led_regulator_level;
        logic [SLOPE_W-1:0] second_led_temp_slope;
        logic [SLOPE_W-1:0] first_led_temp_slope;
        logic photo_reference_select;
        logic [GAIN_W-1:0] photo_gain_code;
        logic [REG_W-1:0] first_led_current_value;
        logic [REG_W-1:0] second_led_current_value;
    } analog_cfg_s;

endpackage : led_photo_cfg_pkg

// file: hw/led_photo_config_registers.sv
// AHB-Lite slave holding the LED regulator, photo control and LED current registers
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/10ps
module led_photo_config_registers (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output led_photo_cfg_pkg::analog_cfg_s analog_cfg,
    output logic level_reserved_q
);

    localparam int NR = led_photo_cfg_pkg::NUM_REGS;
    localparam int RW = led_photo_cfg_pkg::REG_W;

    // Per-slot constants
    localparam logic [RW-1:0] SLOT_RESET [NR] = '{
        led_photo_cfg_pkg::RST_LED_REGULATOR,
        led_photo_cfg_pkg::RST_PHOTO_CONTROL,
        led_photo_cfg_pkg::RST_FIRST_CURRENT,
        led_photo_cfg_pkg::RST_SECOND_CURRENT
    };
    localparam logic [RW-1:0] SLOT_MASK [NR] = '{
        led_photo_cfg_pkg::MASK_LED_REGULATOR,
        led_photo_cfg_pkg::MASK_PHOTO_CONTROL,
        led_photo_cfg_pkg::MASK_FULL,
        led_photo_cfg_pkg::MASK_FULL
    };
    localparam logic [29:0] SLOT_INDEX [NR] = '{
        led_photo_cfg_pkg::IDX_LED_REGULATOR,
        led_photo_cfg_pkg::IDX_PHOTO_CONTROL,
        led_photo_cfg_pkg::IDX_FIRST_CURRENT,
        led_photo_cfg_pkg::IDX_SECOND_CURRENT
    };

    // Bus decode
    logic addr_phase;
    logic lane0_hit;
    logic [NR-1:0] addr_hit;
    logic rd_req;
    logic wr_req;
    logic mapped_hit;
    logic wr_take;
    logic wr_pend_q;
    logic [NR-1:0] wr_slot_q;

    // Storage and read path
    logic [NR-1:0] wr_en;
    logic [RW-1:0] reg_value [NR];
    logic [RW-1:0] wr_byte;
    logic [RW-1:0] wr_masked [NR];
    logic [RW-1:0] slot_read [NR];
    logic [RW-1:0] read_byte;
    logic [led_photo_cfg_pkg::BUS_W-1:0] read_word;

    // Field slices of the stored bytes
    logic [led_photo_cfg_pkg::LEVEL_W-1:0] level_field;
    logic [led_photo_cfg_pkg::SLOPE_W-1:0] second_slope_field;
    logic [led_photo_cfg_pkg::SLOPE_W-1:0] first_slope_field;
    logic ref_select_field;
    logic [led_photo_cfg_pkg::GAIN_W-1:0] gain_field;
    logic [RW-1:0] first_current_field;
    logic [RW-1:0] second_current_field;
    logic level_reserved;

    // Field flops driving the analog settings
    logic [led_photo_cfg_pkg::LEVEL_W-1:0] level_q;
    logic [led_photo_cfg_pkg::SLOPE_W-1:0] second_slope_q;
    logic [led_photo_cfg_pkg::SLOPE_W-1:0] first_slope_q;
    logic ref_select_q;
    logic [led_photo_cfg_pkg::GAIN_W-1:0] gain_q;
    logic [RW-1:0] first_current_q;
    logic [RW-1:0] second_current_q;

    // A transfer is taken when selected, active and the bus is ready
    assign addr_phase = hsel && hready && htrans[1];

    // Read request of a taken transfer
    assign rd_req = addr_phase && !hwrite;

    // Write request of a taken transfer
    assign wr_req = addr_phase && hwrite;

    // Byte lane 0 is covered by word, low half and byte-0 accesses
    always_comb begin
        unique case (hsize)
            led_photo_cfg_pkg::HSIZE_BYTE: lane0_hit = (haddr[1:0] == 2'h0);
            led_photo_cfg_pkg::HSIZE_HALF: lane0_hit = !haddr[1];
            led_photo_cfg_pkg::HSIZE_WORD: lane0_hit = 1'b1;
            default: lane0_hit = 1'b0;
        endcase
    end

    // Word index decode; anything else is unmapped and reads zero
    generate
        for (genvar i = 0; i < NR; i++) begin : g_decode
            assign addr_hit[i] = (haddr[31:led_photo_cfg_pkg::WORD_SHIFT] == SLOT_INDEX[i]);
        end
    endgenerate

    // Any of the four registers hit
    assign mapped_hit = (addr_hit != '0);

    // A write lands only if it covers byte lane 0 of a mapped word
    assign wr_take = wr_req && lane0_hit && mapped_hit;

    // Remember whether a write data phase is pending
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
        end else if (hready) begin
            wr_pend_q <= wr_take;
        end
    end

    // Remember which register the pending write data phase targets
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_slot_q <= '0;
        end else if (hready) begin
            wr_slot_q <= addr_hit;
        end
    end

    // Data phase byte, low lane only; upper lanes carry no bits here
    assign wr_byte = hwdata[RW-1:0];

    // Storage, one byte per register
    generate
        for (genvar i = 0; i < NR; i++) begin : g_reg
            assign wr_en[i] = wr_pend_q && wr_slot_q[i];
            cfg_byte_reg #(
                .RESET_VALUE(SLOT_RESET[i]),
                .WRITE_MASK(SLOT_MASK[i])
            ) u_reg (
                .hclk(hclk),
                .hresetn(hresetn),
                .wr_en(wr_en[i]),
                .wr_data(wr_byte),
                .value_q(reg_value[i])
            );
        end
    endgenerate

    // Per register read byte, forwarding a write still in its data phase
    generate
        for (genvar i = 0; i < NR; i++) begin : g_read
            assign wr_masked[i] = wr_byte & SLOT_MASK[i];
            assign slot_read[i] = !addr_hit[i] ? '0 :
                (wr_en[i] ? wr_masked[i] : reg_value[i]);
        end
    endgenerate

    // Read mux; at most one slot is hit, unmapped words read zero
    always_comb begin
        read_byte = '0;
        for (int i = 0; i < NR; i++) begin
            read_byte = read_byte | slot_read[i];
        end
    end

    // Bus word with the upper lanes zero
    assign read_word = {{(led_photo_cfg_pkg::BUS_W - RW){1'b0}}, read_byte};

    // Read data is captured at the address phase and stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (rd_req) begin
            hrdata <= read_word;
        end
    end

    // Zero wait states: ready in reset and after
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // Every transfer, mapped or not, answers OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= led_photo_cfg_pkg::HRESP_OKAY;
        end else begin
            hresp <= led_photo_cfg_pkg::HRESP_OKAY;
        end
    end

    // Regulator level field
    assign level_field = reg_value[led_photo_cfg_pkg::SLOT_LED_REGULATOR]
        [led_photo_cfg_pkg::LEVEL_LSB +: led_photo_cfg_pkg::LEVEL_W];

    // Second driver slope field
    assign second_slope_field = reg_value[led_photo_cfg_pkg::SLOT_PHOTO_CONTROL]
        [led_photo_cfg_pkg::SECOND_SLOPE_LSB +: led_photo_cfg_pkg::SLOPE_W];

    // First driver slope field
    assign first_slope_field = reg_value[led_photo_cfg_pkg::SLOT_PHOTO_CONTROL]
        [led_photo_cfg_pkg::FIRST_SLOPE_LSB +: led_photo_cfg_pkg::SLOPE_W];

    // Photo reference select bit
    assign ref_select_field = reg_value[led_photo_cfg_pkg::SLOT_PHOTO_CONTROL]
        [led_photo_cfg_pkg::REF_SEL_BIT];

    // Photo gain field
    assign gain_field = reg_value[led_photo_cfg_pkg::SLOT_PHOTO_CONTROL]
        [led_photo_cfg_pkg::GAIN_LSB +: led_photo_cfg_pkg::GAIN_W];

    // First LED current code, whole byte
    assign first_current_field = reg_value[led_photo_cfg_pkg::SLOT_FIRST_CURRENT];

    // Second LED current code, whole byte
    assign second_current_field = reg_value[led_photo_cfg_pkg::SLOT_SECOND_CURRENT];

    // Codes 6 and 7 are stored but flagged as reserved
    assign level_reserved = (level_field > led_photo_cfg_pkg::LEVEL_MAX_VALID);

    // Regulator level code held for the LED supply
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_q <= '0;
        end else begin
            level_q <= level_field;
        end
    end

    // Second driver slope code
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            second_slope_q <= '0;
        end else begin
            second_slope_q <= second_slope_field;
        end
    end

    // First driver slope code
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_slope_q <= '0;
        end else begin
            first_slope_q <= first_slope_field;
        end
    end

    // Photo reference select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_select_q <= 1'b0;
        end else begin
            ref_select_q <= ref_select_field;
        end
    end

    // Photo gain code
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gain_q <= '0;
        end else begin
            gain_q <= gain_field;
        end
    end

    // First LED current code
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_current_q <= '0;
        end else begin
            first_current_q <= first_current_field;
        end
    end

    // Second LED current code
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            second_current_q <= '0;
        end else begin
            second_current_q <= second_current_field;
        end
    end

    // Reserved level status, registered beside the fields
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_reserved_q <= 1'b0;
        end else begin
            level_reserved_q <= level_reserved;
        end
    end

    // Analog settings, each field straight from its own flop
    assign analog_cfg = '{
        led_regulator_level: level_q,
        second_led_temp_slope: second_slope_q,
        first_led_temp_slope: first_slope_q,
        photo_reference_select: ref_select_q,
        photo_gain_code: gain_q,
        first_led_current_value: first_current_q,
        second_led_current_value: second_current_q
    };

endmodule : led_photo_config_registers
